// *** common/tsf_pkg.sv ***
/*
 * Shared types and constants for the transport-stream-over-IP streamer.
 * Assumes one 200 MHz clock and a synchronous, active-low reset.
 */
package tsf_pkg;
	// ************************************************
	// Timing and sizes
	// ************************************************
	localparam int CLK_KHZ = 200000;
	localparam int ACK_TIMEOUT_MS = 1000;
	localparam int ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_MS * CLK_KHZ;
	localparam logic [7:0] TS_PKT_LEN = 8'hBC;
	localparam logic [7:0] PID_HI_IDX = 8'h01;
	localparam logic [7:0] PID_LO_IDX = 8'h02;
	localparam logic [12:0] NULL_PID = 13'h1FFF;
	localparam logic [15:0] COL_PORT_STEP = 16'h0002;
	localparam logic [15:0] ROW_PORT_STEP = 16'h0004;
	localparam logic [4:0] COL_MIN = 5'h01;
	localparam logic [4:0] ROW_MIN = 5'h04;
	localparam logic [4:0] DIM_MAX = 5'h14;
	localparam logic [9:0] MATRIX_MAX = 10'h064;
	localparam logic [7:0] ROW_OFFSET = 8'h01;

	// ************************************************
	// Rate selection in kbit/s; manual limits in Mbit/s
	// ************************************************
	localparam logic [21:0] BITS_PER_BYTE_KHZ = 22'h186A00;
	localparam logic [16:0] RATE_STD_LOW_KBPS = 17'h04BBE;
	localparam logic [16:0] RATE_STD_HIGH_KBPS = 17'h09790;
	localparam logic [6:0] RATE_MANUAL_MIN = 7'h0A;
	localparam logic [6:0] RATE_MANUAL_MAX = 7'h50;
	localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;

	typedef enum logic [1:0] {
		TSF_RATE_STD_LOW = 2'b00,
		TSF_RATE_STD_HIGH = 2'b01,
		TSF_RATE_MANUAL = 2'b10
	} tsf_rate_mode_t;

	typedef enum logic [1:0] {
		TSF_LINK_OFFLINE = 2'b00,
		TSF_LINK_ACTIVE = 2'b01,
		TSF_LINK_FAILED = 2'b10
	} tsf_link_t;

	typedef enum logic [1:0] {
		TSF_KIND_MEDIA = 2'b00,
		TSF_KIND_COLUMN = 2'b01,
		TSF_KIND_ROW = 2'b10
	} tsf_kind_t;

	typedef struct packed {
		logic enable;
		logic src_external;
		logic [31:0] dst_addr;
		logic [15:0] dst_port;
		logic [7:0] ttl;
		logic [7:0] tos;
		logic use_rtp;
		logic drop_nulls;
		logic fec_on;
		logic [4:0] fec_column_count;
		logic [4:0] fec_row_depth;
	} tsf_cfg_t;

	typedef struct packed {
		tsf_kind_t kind;
		logic [31:0] dst_addr;
		logic [15:0] dst_port;
		logic [7:0] ttl;
		logic [7:0] tos;
		logic use_rtp;
		logic [15:0] seq;
		logic [15:0] sn_base;
		logic [7:0] offset;
		logic [7:0] na;
	} tsf_dgram_t;
endpackage

// *** design/tsf_streamer.sv ***
/*
 * Per-stream datagram descriptor generator for transport stream over IP,
 * with optional column/row FEC descriptors and null removal.
 * Assumes 188-byte packets from an internal multiplexer on clk, and from an
 * external serial receiver on pins; the MAC builds frames from descriptors.
 */
`timescale 1ns/1ps
`default_nettype none
module tsf_streamer #(
	parameter int NUM_STREAMS = 2,
	parameter int ACK_TIMEOUT = tsf_pkg::ACK_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] int_data,
	input wire logic int_valid,
	input wire logic int_sop,
	input wire logic [7:0] ext_data,
	input wire logic ext_valid,
	input wire logic ext_sop,
	input wire logic phy_ready,
	input wire logic [NUM_STREAMS-1:0] rx_ack,
	input var tsf_pkg::tsf_cfg_t [NUM_STREAMS-1:0] cfg,
	input var tsf_pkg::tsf_rate_mode_t rate_mode,
	input wire logic [6:0] rate_manual_mbps,
	output logic ts_byte_tick,
	output var tsf_pkg::tsf_dgram_t [NUM_STREAMS-1:0] media_dgram,
	output logic [NUM_STREAMS-1:0] media_valid,
	output var tsf_pkg::tsf_dgram_t [NUM_STREAMS-1:0] column_dgram,
	output logic [NUM_STREAMS-1:0] column_valid,
	output var tsf_pkg::tsf_dgram_t [NUM_STREAMS-1:0] row_dgram,
	output logic [NUM_STREAMS-1:0] row_valid,
	output var tsf_pkg::tsf_link_t [NUM_STREAMS-1:0] link_status,
	output logic [NUM_STREAMS-1:0] fec_active,
	output logic [NUM_STREAMS-1:0] fec_config_error
);
	import tsf_pkg::*;

	// ************************************************
	// Pin synchronisers
	// ************************************************
	// External bytes must hold steady for several clocks around a valid edge
	logic [9:0] ext_meta;
	logic [9:0] ext_sync;
	logic ext_valid_prev;
	logic phy_meta;
	logic phy_ready_s;
	logic ext_take;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ext_meta <= 10'h000;
			ext_sync <= 10'h000;
			ext_valid_prev <= 1'b0;
			phy_meta <= 1'b0;
			phy_ready_s <= 1'b0;
		end else begin
			ext_meta <= {ext_sop, ext_valid, ext_data};
			ext_sync <= ext_meta;
			ext_valid_prev <= ext_sync[8];
			phy_meta <= phy_ready;
			phy_ready_s <= phy_meta;
		end
	end

	assign ext_take = ext_sync[8] && !ext_valid_prev;

	// ************************************************
	// Transport rate pacing
	// ************************************************
	// One tick paces both the multiplexer and the serial output
	logic [21:0] rate_acc;
	logic [21:0] next_rate_acc;
	logic next_ts_byte_tick;
	logic [16:0] rate_kbps;
	logic [6:0] manual_clamped;
	logic [22:0] acc_sum;

	always_comb begin
		manual_clamped = rate_manual_mbps;
		if (rate_manual_mbps < RATE_MANUAL_MIN) begin
			manual_clamped = RATE_MANUAL_MIN;
		end else if (rate_manual_mbps > RATE_MANUAL_MAX) begin
			manual_clamped = RATE_MANUAL_MAX;
		end
		unique case (rate_mode)
			TSF_RATE_STD_LOW: rate_kbps = RATE_STD_LOW_KBPS;
			TSF_RATE_STD_HIGH: rate_kbps = RATE_STD_HIGH_KBPS;
			TSF_RATE_MANUAL: rate_kbps = 17'(manual_clamped * KBPS_PER_MBPS);
			default: rate_kbps = RATE_STD_LOW_KBPS;
		endcase
		acc_sum = {1'b0, rate_acc} + {6'h00, rate_kbps};
		next_ts_byte_tick = acc_sum >= {1'b0, BITS_PER_BYTE_KHZ};
		next_rate_acc = next_ts_byte_tick ? 22'(acc_sum - {1'b0, BITS_PER_BYTE_KHZ}) : acc_sum[21:0];
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rate_acc <= 22'h000000;
			ts_byte_tick <= 1'b0;
		end else begin
			rate_acc <= next_rate_acc;
			ts_byte_tick <= next_ts_byte_tick;
		end
	end

	AST_TICK_SPACED: assert property (@(posedge clk) disable iff (!reset_n)
		ts_byte_tick |=> !ts_byte_tick) else $error("byte tick faster than allowed");

	// ************************************************
	// Per-stream engines
	// ************************************************
	typedef struct packed {
		logic [7:0] byte_cnt;
		logic in_pkt;
		logic [4:0] pid_hi;
		logic null_flag;
		logic [15:0] media_seq;
		logic [15:0] col_seq;
		logic [15:0] row_seq;
		logic [4:0] col_idx;
		logic [4:0] row_idx;
		logic [15:0] row_base;
		logic [15:0] matrix_base;
		logic [4:0] burst_left;
		logic [4:0] burst_k;
		logic waiting;
		logic [31:0] ack_timer;
	} tsf_state_t;

	genvar s;
	generate
		for (s = 0; s < NUM_STREAMS; s++) begin : g_stream
			tsf_state_t st;
			tsf_state_t nst;
			tsf_dgram_t next_media;
			tsf_dgram_t next_column;
			tsf_dgram_t next_row;
			logic next_media_valid;
			logic next_column_valid;
			logic next_row_valid;
			tsf_link_t next_link;
			logic sel_valid;
			logic sel_sop;
			logic [7:0] sel_data;
			logic [7:0] cur_idx;
			logic pkt_end;
			logic keep;
			logic [9:0] matrix;
			logic dims_ok;
			logic fec_ok;
			logic [15:0] prev_seq;
			logic seq_seen;

			always_comb begin
				nst = st;
				// external bytes bypass the multiplexer entirely
				sel_valid = cfg[s].src_external ? ext_take : int_valid;
				sel_sop = cfg[s].src_external ? ext_sync[9] : int_sop;
				sel_data = cfg[s].src_external ? ext_sync[7:0] : int_data;
				cur_idx = sel_sop ? 8'h00 : st.byte_cnt;
				matrix = 10'(cfg[s].fec_column_count) * 10'(cfg[s].fec_row_depth);
				dims_ok = cfg[s].fec_column_count >= COL_MIN && cfg[s].fec_column_count <= DIM_MAX
					&& cfg[s].fec_row_depth >= ROW_MIN && cfg[s].fec_row_depth <= DIM_MAX;
				fec_ok = cfg[s].fec_on && cfg[s].use_rtp && !cfg[s].dst_port[0]
					&& dims_ok && matrix <= MATRIX_MAX;
				pkt_end = sel_valid && st.in_pkt && cur_idx == TS_PKT_LEN - 8'h01;
				keep = !(cfg[s].drop_nulls && st.null_flag);
				if (sel_valid) begin
					nst.byte_cnt = cur_idx + 8'h01;
					if (sel_sop) begin
						nst.in_pkt = 1'b1;
					end
					if (cur_idx == PID_HI_IDX) begin
						nst.pid_hi = sel_data[4:0];
					end
					if (cur_idx == PID_LO_IDX) begin
						nst.null_flag = {st.pid_hi, sel_data} == NULL_PID;
					end
					if (pkt_end) begin
						nst.in_pkt = 1'b0;
					end
				end
				next_media_valid = pkt_end && keep && cfg[s].enable;
				// header fields straight from this stream's setup
				next_media = '{TSF_KIND_MEDIA, cfg[s].dst_addr, cfg[s].dst_port, cfg[s].ttl, cfg[s].tos,
					cfg[s].use_rtp, st.media_seq, 16'h0000, 8'h00, 8'h00};
				next_row = '{TSF_KIND_ROW, cfg[s].dst_addr, 16'(cfg[s].dst_port + ROW_PORT_STEP),
					cfg[s].ttl, cfg[s].tos, 1'b1, st.row_seq, st.row_base, ROW_OFFSET,
					8'(cfg[s].fec_column_count)};
				next_column = '{TSF_KIND_COLUMN, cfg[s].dst_addr, 16'(cfg[s].dst_port + COL_PORT_STEP),
					cfg[s].ttl, cfg[s].tos, 1'b1, st.col_seq, 16'(st.matrix_base + 16'(st.burst_k)),
					8'(cfg[s].fec_column_count), 8'(cfg[s].fec_row_depth)};
				next_row_valid = 1'b0;
				next_column_valid = 1'b0;
				if (next_media_valid && cfg[s].use_rtp) begin
					nst.media_seq = st.media_seq + 16'h0001;
				end
				if (!fec_ok) begin
					nst.col_idx = 5'h00;
					nst.row_idx = 5'h00;
					nst.burst_left = 5'h00;
				end else begin
					// column packets leave as a burst once the matrix fills
					if (st.burst_left != 5'h00) begin
						next_column_valid = 1'b1;
						nst.burst_left = st.burst_left - 5'h01;
						nst.burst_k = st.burst_k + 5'h01;
						nst.col_seq = st.col_seq + 16'h0001;
					end
					if (next_media_valid) begin
						if (st.col_idx == 5'h00) begin
							nst.row_base = st.media_seq;
							if (st.row_idx == 5'h00) begin
								nst.matrix_base = st.media_seq;
							end
						end
						nst.col_idx = st.col_idx + 5'h01;
						if (st.col_idx == cfg[s].fec_column_count - 5'h01) begin
							nst.col_idx = 5'h00;
							next_row_valid = cfg[s].fec_column_count > COL_MIN;
							nst.row_idx = st.row_idx + 5'h01;
							if (st.row_idx == cfg[s].fec_row_depth - 5'h01) begin
								nst.row_idx = 5'h00;
								nst.burst_left = cfg[s].fec_column_count;
								nst.burst_k = 5'h00;
							end
						end
					end
					if (next_row_valid) begin
						nst.row_seq = st.row_seq + 16'h0001;
					end
				end
				// a sent packet must be acknowledged before the timeout
				next_link = link_status[s];
				if (next_media_valid) begin
					nst.waiting = 1'b1;
				end
				if (st.waiting) begin
					nst.ack_timer = st.ack_timer + 32'h00000001;
				end
				if (!phy_ready_s) begin
					next_link = TSF_LINK_OFFLINE;
					nst.waiting = 1'b0;
					nst.ack_timer = 32'h00000000;
				end else if (rx_ack[s]) begin
					next_link = TSF_LINK_ACTIVE;
					nst.waiting = next_media_valid;
					nst.ack_timer = 32'h00000000;
				end else if (st.waiting && st.ack_timer >= 32'(ACK_TIMEOUT - 1)) begin
					next_link = TSF_LINK_FAILED;
					nst.waiting = next_media_valid;
					nst.ack_timer = 32'h00000000;
				end
			end

			always_ff @(posedge clk) begin
				if (!reset_n) begin
					st <= '0;
					media_dgram[s] <= '0;
					column_dgram[s] <= '0;
					row_dgram[s] <= '0;
					media_valid[s] <= 1'b0;
					column_valid[s] <= 1'b0;
					row_valid[s] <= 1'b0;
					link_status[s] <= TSF_LINK_OFFLINE;
					fec_active[s] <= 1'b0;
					fec_config_error[s] <= 1'b0;
				end else begin
					st <= nst;
					media_dgram[s] <= next_media;
					column_dgram[s] <= next_column;
					row_dgram[s] <= next_row;
					media_valid[s] <= next_media_valid;
					column_valid[s] <= next_column_valid;
					row_valid[s] <= next_row_valid;
					link_status[s] <= next_link;
					fec_active[s] <= fec_ok;
					fec_config_error[s] <= cfg[s].fec_on && !fec_ok;
				end
			end

			// Helper: last media sequence number, for the sequence check
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					prev_seq <= 16'h0000;
					seq_seen <= 1'b0;
				end else if (media_valid[s] && media_dgram[s].use_rtp) begin
					prev_seq <= media_dgram[s].seq;
					seq_seen <= 1'b1;
				end
			end

			AST_COL_PORT: assert property (@(posedge clk) disable iff (!reset_n)
				column_valid[s] |-> column_dgram[s].dst_port == 16'($past(cfg[s].dst_port) + COL_PORT_STEP))
				else $error("column FEC port wrong");
			AST_ROW_PORT: assert property (@(posedge clk) disable iff (!reset_n)
				row_valid[s] |-> row_dgram[s].dst_port == 16'($past(cfg[s].dst_port) + ROW_PORT_STEP))
				else $error("row FEC port wrong");
			AST_FEC_OFF: assert property (@(posedge clk) disable iff (!reset_n)
				!fec_ok |=> !column_valid[s] && !row_valid[s]) else $error("FEC sent while off");
			AST_ONE_DIM: assert property (@(posedge clk) disable iff (!reset_n)
				row_valid[s] |-> $past(cfg[s].fec_column_count) > COL_MIN) else $error("row FEC in 1-D mode");
			AST_MATRIX_LIMIT: assert property (@(posedge clk) disable iff (!reset_n)
				(cfg[s].fec_on && matrix > MATRIX_MAX) |=> fec_config_error[s] && !fec_active[s])
				else $error("oversized matrix accepted");
			AST_FEC_SHAPE: assert property (@(posedge clk) disable iff (!reset_n)
				column_valid[s] |-> column_dgram[s].na == 8'($past(cfg[s].fec_row_depth))
				&& column_dgram[s].offset == 8'($past(cfg[s].fec_column_count))) else $error("column shape wrong");
			AST_NULL_DROP: assert property (@(posedge clk) disable iff (!reset_n)
				media_valid[s] |-> !($past(cfg[s].drop_nulls) && $past(st.null_flag))) else $error("null sent");
			AST_HEADER: assert property (@(posedge clk) disable iff (!reset_n)
				media_valid[s] |-> media_dgram[s].ttl == $past(cfg[s].ttl) && media_dgram[s].tos == $past(cfg[s].tos)
				&& media_dgram[s].dst_addr == $past(cfg[s].dst_addr)) else $error("header fields wrong");
			AST_OFFLINE: assert property (@(posedge clk) disable iff (!reset_n)
				!phy_ready_s |=> link_status[s] == TSF_LINK_OFFLINE) else $error("link not offline");
			AST_SEQ_STEP: assert property (@(posedge clk) disable iff (!reset_n)
				(media_valid[s] && media_dgram[s].use_rtp && seq_seen)
				|-> media_dgram[s].seq == 16'(prev_seq + 16'h0001)) else $error("RTP sequence skipped");

			COV_RTP_MEDIA: cover property (@(posedge clk) disable iff (!reset_n)
				media_valid[s] && media_dgram[s].use_rtp);
			COV_ROW_FEC: cover property (@(posedge clk) disable iff (!reset_n) row_valid[s]);
			COV_COL_BURST: cover property (@(posedge clk) disable iff (!reset_n)
				column_valid[s] ##1 column_valid[s]);
			COV_LINK_FAIL: cover property (@(posedge clk) disable iff (!reset_n)
				link_status[s] == TSF_LINK_FAILED);
		end
	endgenerate
endmodule
`default_nettype wire

// *** verification/tsf_receiver_model.sv ***
/*
 * Remote receiving equipment: acknowledges each media packet per stream, except in silent mode.
 * Assumes the streamer's clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tsf_receiver_model #(
	parameter int NUM_STREAMS = 2
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NUM_STREAMS-1:0] media_valid,
	input wire logic [1:0] mode,
	output logic [NUM_STREAMS-1:0] rx_ack
);
	// Mode 0 prompt, 1 slow, 2 silent as with a pulled cable
	logic [4:0][NUM_STREAMS-1:0] dly;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dly <= '0;
		end else begin
			dly <= {dly[3:0], media_valid};
		end
	end
	assign rx_ack = (mode == 2'h0) ? dly[0] : (mode == 2'h1) ? dly[4] : '0;
endmodule
`default_nettype wire

// *** verification/tsf_streamer_bench.sv ***
/*
 * Self-checking bench for tsf_streamer; stream 1 is fed from the serial pins.
 * Assumes tsf_pkg and the receiver model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tsf_streamer_bench;
	import tsf_pkg::*;
	localparam int NS = 2;
	localparam int TMO = 20;
	logic clk = 0, reset_n = 0;
	logic [7:0] int_data = 0, ext_data = 0;
	logic int_valid = 0, int_sop = 0, ext_valid = 0, ext_sop = 0, phy_ready = 1, ts_byte_tick;
	logic [NS-1:0] rx_ack, media_valid, column_valid, row_valid, fec_active, fec_config_error;
	tsf_cfg_t [NS-1:0] cfg;
	tsf_rate_mode_t rate_mode = TSF_RATE_STD_LOW;
	logic [6:0] rate_manual_mbps = 7'h50;
	tsf_dgram_t [NS-1:0] media_dgram, column_dgram, row_dgram;
	tsf_link_t [NS-1:0] link_status;
	logic [1:0] ack_mode = 2'h0;
	tsf_dgram_t exp_q[$];
	int err_count = 0, n_checks = 0;
	int kb[4] = '{19390, 38800, 10000, 80000};
	int cnt;

	initial begin
		forever #2.5 clk = ~clk;
	end

	tsf_streamer #(.NUM_STREAMS(NS), .ACK_TIMEOUT(TMO)) dut (.clk, .reset_n, .int_data, .int_valid, .int_sop,
		.ext_data, .ext_valid, .ext_sop, .phy_ready, .rx_ack, .cfg, .rate_mode, .rate_manual_mbps,
		.ts_byte_tick, .media_dgram, .media_valid, .column_dgram, .column_valid, .row_dgram, .row_valid,
		.link_status, .fec_active, .fec_config_error);
	tsf_receiver_model #(.NUM_STREAMS(NS)) model (.clk, .reset_n, .media_valid, .mode(ack_mode), .rx_ack);

	// ************************************************
	// Checking
	// ************************************************
	task automatic chk(string what, logic [127:0] seen, logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Media descriptors carry no FEC fields; UDP has no sequence
	function automatic tsf_dgram_t norm(tsf_dgram_t d);
		if (d.kind == TSF_KIND_MEDIA) begin
			d.sn_base = '0;
			d.offset = '0;
			d.na = '0;
			if (!d.use_rtp) begin
				d.seq = '0;
			end
		end
		return d;
	endfunction

	function automatic tsf_dgram_t mk(int s, tsf_kind_t k, logic [15:0] step, logic [15:0] sq,
		logic [15:0] sb, logic [7:0] off, logic [7:0] na);
		mk = '{k, cfg[s].dst_addr, cfg[s].dst_port + step, cfg[s].ttl, cfg[s].tos,
			(k != TSF_KIND_MEDIA) | cfg[s].use_rtp, sq, sb, off, na};
	endfunction

	task automatic see(string what, tsf_dgram_t d);
		if (exp_q.size() == 0) begin
			chk({what, " unexpected"}, 1, 0);
		end else begin
			chk(what, norm(d), norm(exp_q.pop_front()));
		end
	endtask

	always @(negedge clk) begin
		for (int s = 0; s < NS; s++) begin
			if (media_valid[s] === 1'b1) see("media", media_dgram[s]);
			if (row_valid[s] === 1'b1) see("row", row_dgram[s]);
			if (column_valid[s] === 1'b1) see("column", column_dgram[s]);
		end
	end

	// ************************************************
	// Drivers
	// ************************************************
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset();
		reset_n <= 1'b0;
		tick(5);
		reset_n <= 1'b1;
		tick(2);
	endtask

	task automatic send_pkt(logic [12:0] pid);
		for (int i = 0; i < 188; i++) begin
			@(negedge clk);
			int_valid <= 1'b1;
			int_sop <= (i == 0);
			int_data <= (i == 0) ? 8'h47 : (i == 1) ? {3'h0, pid[12:8]} : (i == 2) ? pid[7:0] : 8'($urandom);
		end
		@(negedge clk);
		int_valid <= 1'b0;
		int_sop <= 1'b0;
	endtask

	// Slow pin timing keeps the synchroniser margins
	task automatic send_ext();
		for (int i = 0; i < 188; i++) begin
			ext_sop <= (i == 0);
			ext_data <= (i == 0) ? 8'h47 : 8'($urandom);
			tick(4);
			ext_valid <= 1'b1;
			tick(4);
			ext_valid <= 1'b0;
			tick(4);
		end
	endtask

	initial begin
		void'($urandom(60));
		cfg[0] = '{1'b1, 1'b0, 32'hC0A80A14, 16'hC350, 8'h80, 8'($urandom), 1'b0, 1'b1, 1'b0, 5'h01, 5'h04};
		cfg[1] = '{1'b1, 1'b1, 32'hC0A80A15, 16'hC351, 8'h40, 8'h10, 1'b0, 1'b0, 1'b0, 5'h01, 5'h04};
		do_reset();
		chk("valid after reset", {media_valid, column_valid, row_valid}, 0);
		exp_q.push_back(mk(0, TSF_KIND_MEDIA, 0, 0, 0, 0, 0));
		send_pkt(13'h0100);
		send_pkt(NULL_PID);
		cfg[0].drop_nulls <= 1'b0;
		exp_q.push_back(mk(0, TSF_KIND_MEDIA, 0, 0, 0, 0, 0));
		send_pkt(NULL_PID);
		tick(4);
		chk("link active", link_status[0], TSF_LINK_ACTIVE);
		exp_q.push_back(mk(1, TSF_KIND_MEDIA, 0, 0, 0, 0, 0));
		send_ext();
		tick(8);
		for (int m = 0; m < 4; m++) begin
			rate_mode <= (m < 2) ? tsf_rate_mode_t'(m) : TSF_RATE_MANUAL;
			rate_manual_mbps <= (m == 2) ? 7'h0A : 7'h5A;
			tick(100);
			cnt = 0;
			repeat (8000) begin
				@(negedge clk);
				cnt += ts_byte_tick;
			end
			chk("byte ticks", (cnt * 200 >= kb[m] - 200) && (cnt * 200 <= kb[m] + 200), 1);
		end
		cfg[0].use_rtp <= 1'b1;
		cfg[0].fec_on <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			cfg[0].fec_column_count <= (k == 0) ? 5'h08 : (k == 1) ? 5'h14 : 5'h02;
			cfg[0].fec_row_depth <= (k == 0) ? 5'h0F : (k == 1) ? 5'h05 : 5'h04;
			cfg[0].dst_port <= (k == 2) ? 16'hC351 : 16'hC350;
			tick(3);
			chk("fec error", fec_config_error[0], k != 1);
			chk("fec active", fec_active[0], k == 1);
		end
		cfg[0].fec_on <= 1'b0;
		cfg[0].dst_port <= 16'hC350;
		ack_mode <= 2'h2;
		tick(2);
		exp_q.push_back(mk(0, TSF_KIND_MEDIA, 0, 0, 0, 0, 0));
		send_pkt(13'h0101);
		tick(TMO + 5);
		chk("link failed", link_status[0], TSF_LINK_FAILED);
		phy_ready <= 1'b0;
		tick(6);
		chk("link offline", link_status[0], TSF_LINK_OFFLINE);
		phy_ready <= 1'b1;
		ack_mode <= 2'h1;
		cfg[0].fec_on <= 1'b1;
		cfg[0].fec_column_count <= 5'h01;
		do_reset();
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(mk(0, TSF_KIND_MEDIA, 0, 16'(i), 0, 0, 0));
			if (i == 3) exp_q.push_back(mk(0, TSF_KIND_COLUMN, COL_PORT_STEP, 0, 0, 8'h01, 8'h04));
			send_pkt(13'h0100);
		end
		// Let the trailing column burst leave before reset clears it
		tick(4);
		cfg[0].fec_column_count <= 5'h02;
		cfg[0].drop_nulls <= 1'b1;
		do_reset();
		for (int i = 0; i < 8; i++) begin
			exp_q.push_back(mk(0, TSF_KIND_MEDIA, 0, 16'(i), 0, 0, 0));
			if (i % 2 == 1) exp_q.push_back(mk(0, TSF_KIND_ROW, ROW_PORT_STEP, 16'(i / 2), 16'(i - 1), 8'h01, 8'h02));
			for (int k = 0; k < 2 && i == 7; k++) begin
				exp_q.push_back(mk(0, TSF_KIND_COLUMN, COL_PORT_STEP, 16'(k), 16'(k), 8'h02, 8'h04));
			end
			if (i == 2) send_pkt(NULL_PID);
			send_pkt(13'h0100);
		end
		tick(8);
		chk("pending notes", exp_q.size(), 0);
		conclude();
	end

	initial begin
		#400000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
